// ==== testbench/ddsl_host_model.sv ====
// host side serial port model driving the three wire word link
`timescale 1ns/10ps
module ddsl_host_model
	import ddsl_pkg::*;
(
	output ddsl_link_s link
);
	// 400 ns period, well under the 40 MHz ceiling
	localparam int unsigned HALF = 200;
	initial
	begin
		link.frame_strobe_n = 1'b1;
		link.serial_clock = 1'b1;
		link.serial_data_in = 1'b0;
	end
	// ****************************************
	// one frame of n bits, clock idling at idle
	// ****************************************
	task automatic send(input logic [15:0] w, input int unsigned n,
		input logic idle, input logic split);
	begin
		// odd offset keeps the link out of step with clk_sys
		#17;
		link.serial_clock = idle;
		link.frame_strobe_n = 1'b0;
		#(HALF);
		for (int i = 0; i < n; i++)
		begin
			if (split && i == 8)
			begin
				// byte gap with the clock parked high
				link.serial_clock = 1'b1;
				#(3*HALF);
			end
			link.serial_clock = 1'b1;
			link.serial_data_in = w[15-i];
			#(HALF);
			link.serial_clock = 1'b0;
			#(HALF);
		end
		link.serial_clock = idle;
		#(HALF);
		link.frame_strobe_n = 1'b1;
		// released data line: no pull, so show the inverse
		link.serial_data_in = ~link.serial_data_in;
		#(2*HALF);
	end
	endtask
endmodule

// ==== testbench/tb_dds_serial_word_loader.sv ====
// self checking bench for the serial word loader
`timescale 1ns/10ps
module tb_dds_serial_word_loader;
	import ddsl_pkg::*;
	typedef struct packed
	{
		logic [15:0] w;
		logic [APB_AW-1:0] a;
		logic [APB_DW-1:0] e;
	} ddsl_row_s;
	localparam int unsigned TMO = 20000;
	logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, wave, err;
	logic [APB_AW-1:0] paddr;
	logic [APB_DW-1:0] pwdata, prdata, rd;
	ddsl_link_s link;
	int fail_count, cmp_count, cyc, n;
	ddsl_row_s rows [13] = '{
		{16'h2000, REG_CFG, 32'h0000_2000},
		{16'h4000, REG_TUNE_A, 32'h0000_0000},
		{16'h7fff, REG_TUNE_A, 32'h0fff_c000},
		{16'h8123, REG_TUNE_B, 32'h0000_0000},
		{16'hb456, REG_TUNE_B, 32'h0d15_8123},
		{16'hc5a5, REG_PHASE, 32'h0000_05a5},
		{16'he0f1, REG_PHASE, 32'h00f1_05a5},
		{16'h1000, REG_CFG, 32'h0000_1000},
		{16'h4001, REG_TUNE_A, 32'h0000_4000},
		{16'h0000, REG_CFG, 32'h0000_0000},
		{16'h4abc, REG_TUNE_A, 32'h0000_4abc},
		{16'h1000, REG_CFG, 32'h0000_1000},
		{16'h4800, REG_TUNE_A, 32'h0200_0abc}};
	ddsl_loader #(.CLK_SYS_HZ(20_000_000), .FIFO_DEPTH(4)) u_dut (
		.clk_sys(clk_sys), .resetn(resetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link),
		.waveform_out_pin(wave));
	ddsl_host_model u_host (.link(link));
	// ****************************************
	// shared tasks
	// ****************************************
	task final_report;
	begin
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	end
	endtask
	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
	begin
		cmp_count++;
		if (got !== ex)
		begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		int k;
	begin
		k = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		// wait for the answer, only the bench timeout ends this
		while (pready !== 1'b1)
		begin
			@(posedge clk_sys);
			k++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask
	task automatic settle;
	begin
		n = 0;
		do
		begin
			apb(1'b0, REG_STATUS, DATA_ZERO);
			n++;
		end
		while (rd[STAT_LVL_LSB+:LVL_W] !== 4'h0 && n < 20);
		repeat (4) @(posedge clk_sys);
	end
	endtask
	task automatic word(input logic [15:0] w, input logic idle);
	begin
		u_host.send(w, 16, idle, 1'b0);
		settle();
	end
	endtask
	task automatic acc_step(input logic [31:0] ex);
		logic [31:0] first;
	begin
		apb(1'b0, REG_ACC, DATA_ZERO);
		first = rd;
		apb(1'b0, REG_ACC, DATA_ZERO);
		chk("acc_step", ex, (rd - first) & 32'h0fff_ffff);
	end
	endtask
	// ****************************************
	// clock and timeout
	// ****************************************
	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == TMO)
		begin
			fail_count++;
			final_report();
		end
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = DATA_ZERO;
		repeat (8) @(posedge clk_sys);
		chk("wave_rst", 32'h0000_0000, {31'h0000_0000, wave});
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		for (int a = 0; a <= 24; a += 4)
		begin
			apb(1'b0, a[7:0], DATA_ZERO);
			chk("reg_rst", DATA_ZERO, rd);
			chk("reg_rst_err", DATA_ZERO, {31'h0, err});
			chk("ready", 32'h0000_0001, {31'h0, pready});
		end
		foreach (rows[i])
		begin
			word(rows[i].w, 1'b1);
			apb(1'b0, rows[i].a, DATA_ZERO);
			chk("row", rows[i].e, rd);
		end
		word(16'h0800, 1'b1);
		acc_step(32'h0740_8369);
		word(16'h0000, 1'b0);
		acc_step(32'h0600_2034);
		// partial frame must leave the control word alone
		u_host.send(16'h3fff, 9, 1'b1, 1'b0);
		settle();
		apb(1'b0, REG_CFG, DATA_ZERO);
		chk("abort", 32'h0000_0000, rd);
		u_host.send(16'h0028, 16, 1'b1, 1'b1);
		settle();
		apb(1'b0, REG_CFG, DATA_ZERO);
		chk("split", 32'h0000_0028, rd);
		n = 0;
		repeat (80)
		begin
			@(negedge clk_sys);
			n += (wave === 1'b1);
		end
		chk("square_on", 32'h0000_0001, {31'h0, n > 10});
		word(16'h0008, 1'b1);
		n = 0;
		repeat (80)
		begin
			@(negedge clk_sys);
			n += (wave !== 1'b0);
		end
		chk("square_off", 32'h0000_0000, n);
		// frozen accumulator: the pin shows the top bit of the chosen phase
		word(16'h2000, 1'b1);
		word(16'h4000, 1'b1);
		word(16'h4000, 1'b1);
		apb(1'b0, REG_TUNE_A, DATA_ZERO);
		chk("tune_a_zero", DATA_ZERO, rd);
		word(16'he800, 1'b1);
		word(16'h0100, 1'b1);
		apb(1'b0, REG_ACC, DATA_ZERO);
		chk("core_rst", DATA_ZERO, rd);
		word(16'h0428, 1'b1);
		chk("phase_b_pin", 32'h0000_0001, {31'h0, wave});
		word(16'h0028, 1'b1);
		chk("phase_a_pin", 32'h0000_0000, {31'h0, wave});
		apb(1'b0, 8'h1c, DATA_ZERO);
		chk("unmapped_err", 32'h0000_0001, {31'h0, err});
		chk("unmapped_data", DATA_ZERO, rd);
		apb(1'b1, REG_CFG, 32'hffff_ffff);
		apb(1'b0, REG_CFG, DATA_ZERO);
		chk("cfg_ro", 32'h0000_0028, rd);
		// hold words in the fifo until it refuses
		apb(1'b1, REG_CTRL, 32'h0000_0001);
		for (int i = 1; i <= 6; i++)
			u_host.send(i[15:0], 16, 1'b1, 1'b0);
		apb(1'b0, REG_STATUS, DATA_ZERO);
		chk("full_ovf", 32'h0000_0005, rd & 32'h0000_0005);
		apb(1'b1, REG_CTRL, 32'h0000_0002);
		settle();
		apb(1'b0, REG_CFG, DATA_ZERO);
		chk("drain_last", 32'h0000_0005, rd);
		apb(1'b0, REG_STATUS, DATA_ZERO);
		chk("ovf_clr", DATA_ZERO, rd & 32'h0000_0005);
		final_report();
	end
endmodule

// ==== verilog/ddsl_fifo.sv ====
// small word fifo with a registered read port
`timescale 1ns/10ps
module ddsl_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 4,
	parameter int unsigned LW = 4
)(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [WIDTH-1:0] wr_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [WIDTH-1:0] rd_data,
	output logic [LW-1:0] level
);
	localparam int unsigned PW = (DEPTH < 2) ? 1 : $clog2(DEPTH);

	typedef struct packed {
		logic [LW-1:0] cnt;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic out_v;
		logic [WIDTH-1:0] out_d;
	} ddsl_fifo_s;

	ddsl_fifo_s st;
	ddsl_fifo_s next_st;
	logic [WIDTH-1:0] mem [DEPTH];
	logic push;
	logic pop_out;
	logic load;

	if (DEPTH < 2 || DEPTH + 1 >= (1 << LW))
	begin : g_bad_depth
		$error("fifo depth does not fit its level counter");
	end

	function automatic logic [PW-1:0] step_ptr(input logic [PW-1:0] p);
		step_ptr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction

	// ****************************************
	// pointer and output stage
	// ****************************************
	always_comb
	begin
		next_st = st;
		wr_ready = (st.cnt != LW'(DEPTH));
		push = wr_valid && wr_ready;
		pop_out = st.out_v && rd_ready;
		load = (!st.out_v || pop_out) && (st.cnt != '0);
		if (push)
		begin
			next_st.wp = step_ptr(st.wp);
		end
		if (load)
		begin
			next_st.rp = step_ptr(st.rp);
			next_st.out_v = 1'b1;
			next_st.out_d = mem[st.rp];
		end
		else if (pop_out)
		begin
			next_st.out_v = 1'b0;
		end
		if (push && !load)
		begin
			next_st.cnt = LW'(st.cnt + 1'b1);
		end
		else if (load && !push)
		begin
			next_st.cnt = LW'(st.cnt - 1'b1);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	// storage needs no reset; count guards every read
	always_ff @(posedge clk_sys)
	begin
		if (push)
		begin
			mem[st.wp] <= wr_data;
		end
	end

	assign rd_valid = st.out_v;
	assign rd_data = st.out_d;
	assign level = LW'(st.cnt + {{(LW-1){1'b0}}, st.out_v});

endmodule

// ==== verilog/ddsl_loader.sv ====
// serial word loader and keyed oscillator core with an apb register slave
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
module ddsl_loader #(
	parameter int unsigned CLK_SYS_HZ = 20_000_000,
	parameter int unsigned FIFO_DEPTH = 4
)(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [ddsl_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ddsl_pkg::APB_DW-1:0] pwdata,
	output logic [ddsl_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire ddsl_pkg::ddsl_link_s link,
	output logic waveform_out_pin
);
	import ddsl_pkg::*;

	ddsl_core_s st;
	ddsl_core_s next_st;
	logic sclk_fall;
	logic in_frame;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [WORD_W-1:0] app_word;
	logic [LVL_W-1:0] fifo_level;
	logic apply;
	logic [1:0] app_dest;
	logic [TUNE_W-1:0] step;
	logic [PHASE_W-1:0] phase_pt;
	logic msb;
	logic access;
	logic addr_ok;
	logic [APB_DW-1:0] rd_mux;

	// ****************************************
	// elaboration checks
	// ****************************************
	if (CLK_SYS_HZ > MCLK_MAX_HZ)
	begin : g_bad_clk
		$error("core clock above the oscillator limit");
	end
	if (FIFO_DEPTH < 2 || FIFO_DEPTH + 1 >= (1 << LVL_W))
	begin : g_bad_fifo
		$error("fifo depth does not fit the status field");
	end
	function automatic logic [TUNE_W-1:0] put_half(
		input logic [TUNE_W-1:0] old,
		input logic [HALF_W-1:0] half,
		input logic hi
	);
		put_half = hi ? {half, old[HALF_W-1:0]} : {old[TUNE_W-1:HALF_W], half};
	endfunction
	// a change counts only when stages two and three agree
	function automatic logic settle(input logic [2:0] s, input logic f);
		settle = (s[1] == s[2]) ? s[2] : f;
	endfunction
	ddsl_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH),
		.LW(LVL_W)
	) u_fifo (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.wr_valid(st.push_v),
		.wr_ready(fifo_in_ready),
		.wr_data(st.push_word),
		.rd_valid(fifo_out_valid),
		.rd_ready(!st.hold),
		.rd_data(app_word),
		.level(fifo_level)
	);

	always_comb
	begin
		next_st = st;
		// ****************************************
		// pin sampling and serial shifter
		// ****************************************
		// sampled, not clocked by the pin: 40 MHz needs a faster core clock
		next_st.sclk_sync = {st.sclk_sync[1:0], link.serial_clock};
		next_st.fa_sync = {st.fa_sync[1:0], ~link.frame_strobe_n};
		next_st.sd_sync = {st.sd_sync[1:0], link.serial_data_in};
		next_st.sclk_f = settle(st.sclk_sync, st.sclk_f);
		next_st.fa_f = settle(st.fa_sync, st.fa_f);
		next_st.sd_f = settle(st.sd_sync, st.sd_f);
		// edges only, so clock idle level never matters
		sclk_fall = st.sclk_f && !next_st.sclk_f;
		in_frame = st.fa_f;
		next_st.push_v = 1'b0;
		unique case (st.link_st)
			DDSL_LINK_IDLE:
			begin
				next_st.bitcnt = '0;
				if (in_frame)
				begin
					next_st.link_st = DDSL_LINK_SHIFT;
				end
			end
			DDSL_LINK_SHIFT:
			begin
				if (!in_frame)
				begin
					// a short frame drops its partial word
					next_st.link_st = DDSL_LINK_IDLE;
					next_st.bitcnt = '0;
				end
				else if (sclk_fall)
				begin
					next_st.shift = {st.shift[WORD_W-2:0], st.sd_f};
					next_st.bitcnt = BITCNT_W'(st.bitcnt + 1'b1);
					if (st.bitcnt == LAST_BIT)
					begin
						next_st.push_v = 1'b1;
						next_st.push_word = {st.shift[WORD_W-2:0], st.sd_f};
					end
				end
			end
		endcase
		// ****************************************
		// word routing
		// ****************************************
		apply = fifo_out_valid && !st.hold;
		app_dest = app_word[F_DEST_LSB +: 2];
		if (apply)
		begin
			unique case (app_dest)
				DEST_CTRL:
				begin
					next_st.ctrl = app_word;
					next_st.pend_v = 1'b0;
				end
				DEST_TUNE_A, DEST_TUNE_B:
				begin
					if (!st.ctrl[F_FULL_LOAD])
					begin
						if (app_dest == DEST_TUNE_A)
						begin
							next_st.tune_a = put_half(st.tune_a,
								app_word[HALF_W-1:0], st.ctrl[F_HLB]);
						end
						else
						begin
							next_st.tune_b = put_half(st.tune_b,
								app_word[HALF_W-1:0], st.ctrl[F_HLB]);
						end
					end
					else if (st.pend_v && st.pend_dest == app_dest)
					begin
						next_st.pend_v = 1'b0;
						if (app_dest == DEST_TUNE_A)
						begin
							next_st.tune_a = {app_word[HALF_W-1:0], st.pend_lo};
						end
						else
						begin
							next_st.tune_b = {app_word[HALF_W-1:0], st.pend_lo};
						end
					end
					else
					begin
						// another address restarts the pair
						next_st.pend_v = 1'b1;
						next_st.pend_dest = app_dest;
						next_st.pend_lo = app_word[HALF_W-1:0];
					end
				end
				DEST_PHASE:
				begin
					next_st.phase_b = app_word[F_PH_WHICH]
						? app_word[PHASE_W-1:0] : st.phase_b;
					next_st.phase_a = app_word[F_PH_WHICH]
						? st.phase_a : app_word[PHASE_W-1:0];
				end
			endcase
		end
		// ****************************************
		// oscillator core
		// ****************************************
		step = st.ctrl[F_FSEL] ? st.tune_b : st.tune_a;
		phase_pt = PHASE_W'(st.acc[TUNE_W-1 -: PHASE_W]
			+ (st.ctrl[F_PSEL] ? st.phase_b : st.phase_a));
		msb = phase_pt[PHASE_W-1];
		if (st.ctrl[F_RST])
		begin
			next_st.acc = '0;
			next_st.msb_q = 1'b0;
			next_st.div_q = 1'b0;
			next_st.wave = 1'b0;
		end
		else
		begin
			next_st.acc = TUNE_W'(st.acc + step);
			next_st.msb_q = msb;
			if (msb && !st.msb_q)
			begin
				next_st.div_q = !st.div_q;
			end
			// analogue paths are not modelled, pin rests low then
			next_st.wave = st.ctrl[F_OPBIT]
				&& (st.ctrl[F_DIV2] ? msb : st.div_q);
		end
		// ****************************************
		// apb slave
		// ****************************************
		access = psel && penable;
		rd_mux = DATA_ZERO;
		addr_ok = 1'b1;
		unique case ({paddr[APB_AW-1:2], 2'h0})
			REG_CTRL: rd_mux[CTRL_HOLD] = st.hold;
			REG_STATUS:
			begin
				rd_mux[STAT_OVF] = st.overflow;
				rd_mux[STAT_BUSY] = (st.link_st == DDSL_LINK_SHIFT);
				rd_mux[STAT_FULL] = !fifo_in_ready;
				rd_mux[STAT_BITS_LSB +: BITCNT_W] = st.bitcnt;
				rd_mux[STAT_LVL_LSB +: LVL_W] = fifo_level;
			end
			REG_CFG: rd_mux[WORD_W-1:0] = st.ctrl;
			REG_TUNE_A: rd_mux[TUNE_W-1:0] = st.tune_a;
			REG_TUNE_B: rd_mux[TUNE_W-1:0] = st.tune_b;
			REG_PHASE:
			begin
				rd_mux[PHASE_W-1:0] = st.phase_a;
				rd_mux[PHASE_B_LSB +: PHASE_W] = st.phase_b;
			end
			REG_ACC: rd_mux[TUNE_W-1:0] = st.acc;
			default: addr_ok = 1'b0;
		endcase
		if (psel && !penable)
		begin
			next_st.prdata = rd_mux;
		end
		if (access && pwrite && {paddr[APB_AW-1:2], 2'h0} == REG_CTRL)
		begin
			next_st.hold = pwdata[CTRL_HOLD];
			if (pwdata[CTRL_OVF_CLR])
			begin
				next_st.overflow = 1'b0;
			end
		end
		// a lost word outranks a clear in the same cycle
		if (st.push_v && !fifo_in_ready)
		begin
			next_st.overflow = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = 1'b1;
	assign pslverr = access && !addr_ok;
	assign waveform_out_pin = st.wave;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	AST_BIT_ON_FALL: assert property (
		st.link_st == DDSL_LINK_SHIFT && in_frame && sclk_fall
		|=> st.bitcnt == BITCNT_W'($past(st.bitcnt) + 1'b1))
		else $error("bit count did not advance on a falling edge");
	AST_MSB_FIRST: assert property (
		st.link_st == DDSL_LINK_SHIFT && in_frame && sclk_fall
		|=> st.shift == {$past(st.shift[WORD_W-2:0]), $past(st.sd_f)})
		else $error("serial bit not shifted in at the low end");
	AST_NO_FRAME_NO_WORD: assert property (
		!in_frame |=> st.bitcnt == '0 && !st.push_v)
		else $error("activity outside a frame");
	AST_WORD_AFTER_16: assert property (
		st.link_st == DDSL_LINK_SHIFT && in_frame && sclk_fall
		&& st.bitcnt == LAST_BIT |=> st.push_v ##1 !st.push_v)
		else $error("sixteenth bit did not deliver one word");
	AST_CTRL_ROUTE: assert property (
		apply && app_dest == DEST_CTRL |=> st.ctrl == $past(app_word))
		else $error("control word not stored");
	AST_FULL_PAIR: assert property (
		apply && app_dest == DEST_TUNE_A && st.ctrl[F_FULL_LOAD]
		&& st.pend_v && st.pend_dest == DEST_TUNE_A
		|=> st.tune_a == {$past(app_word[HALF_W-1:0]), $past(st.pend_lo)})
		else $error("tuning pair not joined low half first");
	AST_PHASE_LOAD: assert property (
		apply && app_dest == DEST_PHASE |=> ($past(app_word[F_PH_WHICH])
		? st.phase_b : st.phase_a) == $past(app_word[PHASE_W-1:0]))
		else $error("phase word landed in the wrong register");
	AST_ACC_STEP: assert property (
		!st.ctrl[F_RST] |=> st.acc == TUNE_W'($past(st.acc) + $past(step)))
		else $error("accumulator did not add the chosen tuning word");
	AST_SQUARE_OUT: assert property (
		st.ctrl[F_OPBIT] && st.ctrl[F_DIV2] && !st.ctrl[F_RST]
		|=> waveform_out_pin == $past(msb))
		else $error("square output does not follow the top phase bit");
	AST_OVF_STICKY: assert property (
		st.push_v && !fifo_in_ready |=> st.overflow)
		else $error("lost word not flagged");

	CV_WORD: cover property (st.push_v);
	CV_FSK: cover property (apply && app_dest == DEST_CTRL
		&& app_word[F_FSEL] != st.ctrl[F_FSEL]);
	CV_PAIR: cover property (apply && st.ctrl[F_FULL_LOAD] && st.pend_v);
	CV_FULL: cover property (!fifo_in_ready);

endmodule

// ==== verilog/ddsl_pkg.sv ====
// constants, state and carrier types shared by the serial word loader
package ddsl_pkg;

	// ****************************************
	// widths and limits
	// ****************************************
	localparam int unsigned WORD_W = 16;
	localparam int unsigned TUNE_W = 28;
	localparam int unsigned HALF_W = 14;
	localparam int unsigned PHASE_W = 12;
	localparam int unsigned BITCNT_W = 4;
	localparam int unsigned APB_AW = 8;
	localparam int unsigned APB_DW = 32;
	localparam int unsigned LVL_W = 4;
	localparam int unsigned MCLK_MAX_HZ = 25_000_000;
	localparam int unsigned SCLK_MAX_HZ = 40_000_000;
	localparam logic [BITCNT_W-1:0] LAST_BIT = 4'hf;
	localparam logic [APB_DW-1:0] DATA_ZERO = 32'h0000_0000;

	// ****************************************
	// serial word fields
	// ****************************************
	localparam int unsigned F_DEST_LSB = 14;
	localparam int unsigned F_FULL_LOAD = 13;
	localparam int unsigned F_HLB = 12;
	localparam int unsigned F_FSEL = 11;
	localparam int unsigned F_PSEL = 10;
	localparam int unsigned F_RST = 8;
	localparam int unsigned F_OPBIT = 5;
	localparam int unsigned F_DIV2 = 3;
	localparam int unsigned F_PH_WHICH = 13;
	localparam logic [1:0] DEST_CTRL = 2'h0;
	localparam logic [1:0] DEST_TUNE_A = 2'h1;
	localparam logic [1:0] DEST_TUNE_B = 2'h2;
	localparam logic [1:0] DEST_PHASE = 2'h3;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] REG_CFG = 8'h08;
	localparam logic [APB_AW-1:0] REG_TUNE_A = 8'h0c;
	localparam logic [APB_AW-1:0] REG_TUNE_B = 8'h10;
	localparam logic [APB_AW-1:0] REG_PHASE = 8'h14;
	localparam logic [APB_AW-1:0] REG_ACC = 8'h18;
	localparam int unsigned CTRL_HOLD = 0;
	localparam int unsigned CTRL_OVF_CLR = 1;
	localparam int unsigned STAT_OVF = 0;
	localparam int unsigned STAT_BUSY = 1;
	localparam int unsigned STAT_FULL = 2;
	localparam int unsigned STAT_BITS_LSB = 4;
	localparam int unsigned STAT_LVL_LSB = 8;
	localparam int unsigned PHASE_B_LSB = 16;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic {DDSL_LINK_IDLE, DDSL_LINK_SHIFT} ddsl_link_e;

	typedef struct packed {
		logic frame_strobe_n;
		logic serial_clock;
		logic serial_data_in;
	} ddsl_link_s;

	typedef struct packed {
		ddsl_link_e link_st;
		logic [2:0] sclk_sync;
		logic [2:0] fa_sync;
		logic [2:0] sd_sync;
		logic sclk_f;
		logic fa_f;
		logic sd_f;
		logic [WORD_W-1:0] shift;
		logic [BITCNT_W-1:0] bitcnt;
		logic push_v;
		logic [WORD_W-1:0] push_word;
		logic [WORD_W-1:0] ctrl;
		logic [TUNE_W-1:0] tune_a;
		logic [TUNE_W-1:0] tune_b;
		logic [HALF_W-1:0] pend_lo;
		logic pend_v;
		logic [1:0] pend_dest;
		logic [PHASE_W-1:0] phase_a;
		logic [PHASE_W-1:0] phase_b;
		logic [TUNE_W-1:0] acc;
		logic msb_q;
		logic div_q;
		logic wave;
		logic hold;
		logic overflow;
		logic [APB_DW-1:0] prdata;
	} ddsl_core_s;

endpackage
